// ---- tune_pkg.sv ----
// Constants, gain tables and register map of the autotuning sequencer
package tune_pkg;

   // ------------------------------------------------------------
   // Widths and timing
   // ------------------------------------------------------------
   localparam int          AW                = 8;
   localparam int          DW                = 16;
   localparam int          NPAR              = 19;
   localparam int          PIN_W             = 5;
   localparam int          MAX_CYCLES        = 5;
   localparam int          ACCEL_DOUBLE_FROM = 3;
   localparam int          CLK_HZ            = 20_000_000;
   localparam int          TEST_CYCLE_S      = 15;
   localparam longint      TEST_CYCLE_CLKS   = longint'(TEST_CYCLE_S) * longint'(CLK_HZ);

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_STATUS    = 8'h01;
   localparam logic [7:0]  A_ACCEL     = 8'h02;
   localparam logic [7:0]  A_PARAM     = 8'h10;
   localparam int          CTRL_START  = 0;
   localparam int          CTRL_RIG    = 4;
   localparam int          CTRL_PAT    = 8;
   localparam logic [15:0] ACCEL_RST   = 16'h0010;

   // ------------------------------------------------------------
   // Gain parameter slots
   // ------------------------------------------------------------
   localparam int P_PG1 = 0;
   localparam int P_SG1 = 1;
   localparam int P_SIT1 = 2;
   localparam int P_SFB1 = 3;
   localparam int P_TF1 = 4;
   localparam int P_FF_AMT = 5;
   localparam int P_FF_FILT = 6;
   localparam int P_PG2 = 7;
   localparam int P_SG2 = 8;
   localparam int P_SIT2 = 9;
   localparam int P_SFB2 = 10;
   localparam int P_TF2 = 11;
   localparam int P_INERTIA = 12;
   localparam int P_GS_MODE = 13;
   localparam int P_GS_SET = 14;
   localparam int P_GS_TIME = 15;
   localparam int P_GS_LEVEL = 16;
   localparam int P_GS_HYST = 17;
   localparam int P_PG_SW_TIME = 18;

   // ------------------------------------------------------------
   // Rigidity tables and fixed values
   // ------------------------------------------------------------
   localparam logic [15:0] PG1_TBL [16] = '{16'h001B, 16'h0020, 16'h0027, 16'h0030, 16'h003F, 16'h0048,
      16'h005A, 16'h006C, 16'h0087, 16'h00A2, 16'h00CE, 16'h00FB, 16'h0131, 16'h0179, 16'h01C1, 16'h022D};
   localparam logic [15:0] SG_TBL [16] = '{16'h000F, 16'h0012, 16'h0016, 16'h001B, 16'h0023, 16'h0028,
      16'h0032, 16'h003C, 16'h004B, 16'h005A, 16'h0073, 16'h008C, 16'h00AA, 16'h00D2, 16'h00FA, 16'h0136};
   localparam logic [15:0] SIT1_TBL [16] = '{16'h0025, 16'h001F, 16'h0019, 16'h0015, 16'h0010, 16'h000E,
      16'h000C, 16'h000B, 16'h0009, 16'h0008, 16'h0007, 16'h0006, 16'h0005, 16'h0004, 16'h0004, 16'h0003};
   localparam logic [15:0] TF1_TBL [16] = '{16'h0098, 16'h007E, 16'h0067, 16'h0054, 16'h0041, 16'h0039,
      16'h002D, 16'h0026, 16'h001E, 16'h0019, 16'h0019, 16'h0019, 16'h0019, 16'h0019, 16'h0019, 16'h0019};
   localparam logic [15:0] PG2_TBL [16] = '{16'h001F, 16'h0026, 16'h002E, 16'h0039, 16'h0049, 16'h0054,
      16'h0069, 16'h007E, 16'h009D, 16'h00BC, 16'h00F1, 16'h0125, 16'h0164, 16'h01B8, 16'h020C, 16'h0289};
   localparam logic [15:0] TF2_TBL [16] = '{16'h0098, 16'h007E, 16'h0067, 16'h0054, 16'h0041, 16'h0039,
      16'h002D, 16'h0026, 16'h001E, 16'h0019, 16'h0014, 16'h0010, 16'h000D, 16'h000B, 16'h000A, 16'h000A};
   localparam logic [15:0] SIT2_FIX   = 16'h03E8;
   localparam logic [15:0] SFB_FIX    = 16'h0000;
   localparam logic [15:0] FF_AMT_FIX = 16'h012C;
   localparam logic [15:0] FF_FLT_FIX = 16'h0032;
   localparam logic [15:0] GS_MODE_FIX = 16'h0001;
   localparam logic [15:0] GS_SET_FIX = 16'h000A;
   localparam logic [15:0] GS_TIME_FIX = 16'h001E;
   localparam logic [15:0] GS_LVL_FIX = 16'h0032;
   localparam logic [15:0] GS_HYS_FIX = 16'h0021;
   localparam logic [15:0] PG_SW_FIX  = 16'h0014;

   function automatic logic [NPAR-1:0][15:0] gain_set(input logic [3:0] r, input logic [15:0] ine);
      logic [NPAR-1:0][15:0] g;
      g = '0;
      g[P_PG1] = PG1_TBL[r];
      g[P_SG1] = SG_TBL[r];
      g[P_SIT1] = SIT1_TBL[r];
      g[P_SFB1] = SFB_FIX;
      g[P_TF1] = TF1_TBL[r];
      g[P_FF_AMT] = FF_AMT_FIX;
      g[P_FF_FILT] = FF_FLT_FIX;
      g[P_PG2] = PG2_TBL[r];
      g[P_SG2] = SG_TBL[r];
      g[P_SIT2] = SIT2_FIX;
      g[P_SFB2] = SFB_FIX;
      g[P_TF2] = TF2_TBL[r];
      g[P_INERTIA] = ine;
      g[P_GS_MODE] = GS_MODE_FIX;
      g[P_GS_SET] = GS_SET_FIX;
      g[P_GS_TIME] = GS_TIME_FIX;
      g[P_GS_LEVEL] = GS_LVL_FIX;
      g[P_GS_HYST] = GS_HYS_FIX;
      g[P_PG_SW_TIME] = PG_SW_FIX;
      return g;
   endfunction

   localparam logic [NPAR-1:0][15:0] PARS_RST = gain_set(4'h0, 16'h0000);

endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync
#(
   parameter int W = 1
)
(
   // Clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   // Pins and clean levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_s;

   sync_s sync_ff;
   sync_s nxt_sync;

   // ------------------------------------------------------------
   // Stages
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_sync = sync_ff;
      nxt_sync.s1 = pin_in;
      nxt_sync.s2 = sync_ff.s1;
      nxt_sync.s3 = sync_ff.s2;
      for (int i = 0; i < W; i++)
      begin
         if (sync_ff.s2[i] == sync_ff.s3[i])
         begin
            nxt_sync.lvl[i] = sync_ff.s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync_ff <= '0;
      end
      else
      begin
         sync_ff <= nxt_sync;
      end
   end

   assign level_out = sync_ff.lvl;

endmodule

// ---- servo_autotune_sequencer.sv ----
// Autotuning sequencer: test motion, abort handling and gain loading
// Function
// - Test motion repeats at most five cycles
// - Acceleration doubles each cycle from the third
// - Early end or held acceleration is no error
// - Rigidity is one hex digit, sixteen entries
// - Pattern 0: two turns each way, fifteen seconds
// - Drive error, servo off, clear, limit abort
// - Oscillation aborts the run
// - Abort restores gains held before the run
// - Motor keeps moving unless an error occurs
// - No load stores inertia ratio zero
// - Position gain 1 and speed gains from table
// - Position gain 2 from table
// - Speed integral constant 1 from table
// - Integral constant 2 fixed, feedback filters zero
// - Torque filter constants from table
// - Estimated inertia ratio written every entry
// - Feed-forward amount and filter fixed
// - Gain-switching parameters fixed
// - Rigidity sets defaults, success overwrites gains
// - Prohibit inputs ignored while a run is active (honoured in idle), full torque limit allowed
`timescale 1ns/10ps
module servo_autotune_sequencer
#(
   parameter logic [31:0] CYCLE_CLKS = 32'(tune_pkg::TEST_CYCLE_CLKS)
)
(
   // Clock and reset
   input  wire logic                      ref_clk_in,
   input  wire logic                      rst_in,
   // Register port
   input  wire logic [tune_pkg::AW-1:0]   addr_in,
   input  wire logic [tune_pkg::DW-1:0]   wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [tune_pkg::DW-1:0]   rdata_out,
   // Drive pins
   input  wire logic                      run_cmd_in,
   input  wire logic                      deviation_counter_clear_in,
   input  wire logic                      limit_near_in,
   input  wire logic                      fwd_prohibit_in,
   input  wire logic                      rev_prohibit_in,
   // Estimator and drive monitors
   input  wire logic                      drive_error_in,
   input  wire logic                      torque_sat_in,
   input  wire logic                      oscillation_in,
   input  wire logic                      est_done_in,
   input  wire logic                      accel_hold_in,
   input  wire logic                      no_load_in,
   input  wire logic [tune_pkg::DW-1:0]   inertia_est_in,
   // Motion command and status
   output logic                           motor_run_out,
   output logic                           motor_fwd_out,
   output logic      [tune_pkg::DW-1:0]   accel_out,
   output logic                           torque_limit_full_out,
   output logic                           fwd_inhibit_out,
   output logic                           rev_inhibit_out,
   output logic                           tune_busy_out,
   output logic                           tune_err_out
);
   import tune_pkg::*;

   if (CYCLE_CLKS < 32'h0000_0004)
   begin : g_chk
      $error("CYCLE_CLKS too small");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_FWD, S_REV} seq_e;

   typedef struct packed {
      seq_e                  st;
      logic [2:0]            cyc;
      logic [31:0]           tmr;
      logic [15:0]           accel;
      logic [15:0]           accel_base;
      logic [3:0]            rig;
      logic [3:0]            pat;
      logic                  conv;
      logic                  err;
      logic                  done;
      logic                  run;
      logic                  fwd;
      logic                  inh_fwd;
      logic                  inh_rev;
      logic [15:0]           rdata;
      logic [NPAR-1:0][15:0] pars;
      logic [NPAR-1:0][15:0] save;
   } state_s;

   localparam state_s ST_RST = '{st: S_IDLE, accel_base: ACCEL_RST, pars: PARS_RST, save: PARS_RST,
                                 default: '0};

   state_s           state_ff;
   state_s           nxt_state;
   logic [PIN_W-1:0] pins;
   logic             run_s;
   logic             clr_s;
   logic             lim_s;
   logic             busy;
   logic             abort_c;
   logic             turn_c;
   logic             finish_c;
   logic [4:0]       pidx;

   // Phase length: pattern 0 runs two turns per direction, others one
   function automatic logic [31:0] phase_len(input logic [3:0] pat);
      return (pat == 4'h0) ? (CYCLE_CLKS >> 1) - 32'h0000_0001 : (CYCLE_CLKS >> 2) - 32'h0000_0001;
   endfunction

   // Full-width window compare, so high addresses cannot alias onto a gain slot
   function automatic logic par_hit(input logic [AW-1:0] a);
      return a >= A_PARAM && (a - A_PARAM) < 8'(NPAR);
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   pin_sync #(
      .W (PIN_W)
   ) u_pin_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .pin_in     ({run_cmd_in, deviation_counter_clear_in, limit_near_in, fwd_prohibit_in, rev_prohibit_in}),
      .level_out  (pins)
   );

   assign run_s = pins[4];
   assign clr_s = pins[3];
   assign lim_s = pins[2];
   assign busy  = state_ff.st != S_IDLE;
   assign pidx  = 5'(addr_in - A_PARAM);

   // Any fault in the run ends it at once; monitors share one priority
   assign abort_c = busy && (drive_error_in || !run_s || clr_s || lim_s
                             || torque_sat_in
                             || oscillation_in);
   assign turn_c   = busy && !abort_c && state_ff.st == S_REV && state_ff.tmr == 32'h0000_0000;
   assign finish_c = turn_c && (state_ff.cyc == 3'(MAX_CYCLES) || state_ff.conv || est_done_in);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.rdata = '0;
      if (rd_in)
      begin
         case (addr_in)
            A_CTRL:   nxt_state.rdata = {4'h0, state_ff.pat, state_ff.rig, 4'h0};
            A_STATUS: nxt_state.rdata = {9'h000, state_ff.cyc, 1'b0, state_ff.done, state_ff.err, busy};
            A_ACCEL:  nxt_state.rdata = state_ff.accel_base;
            default:
            begin
               if (par_hit(addr_in))
               begin
                  nxt_state.rdata = state_ff.pars[pidx];
               end
            end
         endcase
      end
      // Writes while a run is active are dropped so the saved set stays coherent
      if (wr_in && !busy)
      begin
         case (addr_in)
            A_CTRL:
            begin
               nxt_state.rig = wdata_in[CTRL_RIG +: 4];
               nxt_state.pat = wdata_in[CTRL_PAT +: 4];
               if (wdata_in[CTRL_START] && run_s)
               begin
                  nxt_state.save = state_ff.pars;
                  nxt_state.err = 1'b0;
                  nxt_state.done = 1'b0;
                  nxt_state.conv = 1'b0;
                  nxt_state.cyc = 3'd1;
                  nxt_state.accel = state_ff.accel_base;
                  nxt_state.st = S_FWD;
                  nxt_state.fwd = 1'b1;
                  nxt_state.tmr = phase_len(wdata_in[CTRL_PAT +: 4]);
               end
            end
            A_ACCEL:  nxt_state.accel_base = wdata_in;
            default:
            begin
               if (par_hit(addr_in))
               begin
                  nxt_state.pars[pidx] = wdata_in;
               end
            end
         endcase
      end
      if (busy)
      begin
         if (est_done_in)
         begin
            nxt_state.conv = 1'b1;
         end
         if (abort_c)
         begin
            nxt_state.st = S_IDLE;
            nxt_state.pars = state_ff.save;
            nxt_state.err = 1'b1;
         end
         else if (state_ff.tmr != 32'h0000_0000)
         begin
            nxt_state.tmr = state_ff.tmr - 32'h0000_0001;
         end
         else if (state_ff.st == S_FWD)
         begin
            nxt_state.st = S_REV;
            nxt_state.fwd = 1'b0;
            nxt_state.tmr = phase_len(state_ff.pat);
         end
         else if (finish_c)
         begin
            // Early finish is a normal end, the error flag stays clear
            nxt_state.st = S_IDLE;
            nxt_state.done = 1'b1;
            nxt_state.pars = gain_set(state_ff.rig, no_load_in ? 16'h0000 : inertia_est_in);
         end
         else
         begin
            nxt_state.cyc = state_ff.cyc + 3'd1;
            nxt_state.st = S_FWD;
            nxt_state.fwd = 1'b1;
            nxt_state.tmr = phase_len(state_ff.pat);
            // Held acceleration under load is accepted without complaint
            if (state_ff.cyc >= 3'(ACCEL_DOUBLE_FROM - 1) && !accel_hold_in)
            begin
               nxt_state.accel = {state_ff.accel[14:0], 1'b0};
            end
         end
      end
      nxt_state.run = nxt_state.st != S_IDLE;
      nxt_state.inh_fwd = pins[1] && nxt_state.st == S_IDLE;
      nxt_state.inh_rev = pins[0] && nxt_state.st == S_IDLE;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_ff <= ST_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata_out             = state_ff.rdata;
   assign motor_run_out         = state_ff.run;
   assign motor_fwd_out         = state_ff.fwd;
   assign accel_out             = state_ff.accel;
   assign torque_limit_full_out = state_ff.run;
   assign fwd_inhibit_out       = state_ff.inh_fwd;
   assign rev_inhibit_out       = state_ff.inh_rev;
   assign tune_busy_out         = state_ff.run;
   assign tune_err_out          = state_ff.err;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_abort;
      busy && abort_c;
   endsequence

   sequence s_finish;
      finish_c;
   endsequence

   sequence s_turn;
      turn_c && !finish_c;
   endsequence

   property p_max_cycles;
      busy |-> (state_ff.cyc >= 3'd1 && state_ff.cyc <= 3'(MAX_CYCLES));
   endproperty
   a_max_cycles: assert property (p_max_cycles) else $error("cycle count out of range");

   property p_accel_double;
      (s_turn and (state_ff.cyc >= 3'd2 && !accel_hold_in)) |=> state_ff.accel == {$past(state_ff.accel[14:0]), 1'b0};
   endproperty
   a_accel_double: assert property (p_accel_double) else $error("acceleration not doubled");

   property p_accel_early;
      (s_turn and state_ff.cyc == 3'd1) |=> $stable(state_ff.accel);
   endproperty
   a_accel_early: assert property (p_accel_early) else $error("acceleration changed too early");

   property p_finish_ok;
      s_finish |=> !state_ff.err && state_ff.done && !motor_run_out;
   endproperty
   a_finish_ok: assert property (p_finish_ok) else $error("normal end flagged as error");

   property p_pat0_phase;
      (!busy && wr_in && addr_in == A_CTRL && wdata_in[CTRL_START] && run_s && wdata_in[CTRL_PAT +: 4] == 4'h0)
         |=> state_ff.tmr == (CYCLE_CLKS >> 1) - 32'h0000_0001 && motor_fwd_out;
   endproperty
   a_pat0_phase: assert property (p_pat0_phase) else $error("pattern 0 phase length wrong");

   property p_start_needs_run;
      (!busy && !run_s) |=> !busy;
   endproperty
   a_start_needs_run: assert property (p_start_needs_run) else $error("run began with servo off");

   property p_abort;
      s_abort |=> state_ff.err && !motor_run_out && !busy;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not flagged");

   property p_restore;
      s_abort |=> state_ff.pars == $past(state_ff.save);
   endproperty
   a_restore: assert property (p_restore) else $error("gains not restored");

   property p_keep_moving;
      (busy && !abort_c && !finish_c) |=> motor_run_out && torque_limit_full_out;
   endproperty
   a_keep_moving: assert property (p_keep_moving) else $error("motor stopped without error");

   property p_no_load;
      (s_finish and no_load_in) |=> state_ff.pars[P_INERTIA] == 16'h0000;
   endproperty
   a_no_load: assert property (p_no_load) else $error("no-load inertia not zero");

   property p_table;
      s_finish |=> state_ff.pars[P_PG1] == PG1_TBL[state_ff.rig] && state_ff.pars[P_SG1] == state_ff.pars[P_SG2]
         && state_ff.pars[P_PG2] == PG2_TBL[state_ff.rig] && state_ff.pars[P_SIT1] == SIT1_TBL[state_ff.rig]
         && state_ff.pars[P_TF2] == TF2_TBL[state_ff.rig];
   endproperty
   a_table: assert property (p_table) else $error("table gains wrong");

   property p_fixed;
      s_finish |=> state_ff.pars[P_SIT2] == SIT2_FIX && state_ff.pars[P_FF_AMT] == FF_AMT_FIX
         && state_ff.pars[P_GS_HYST] == GS_HYS_FIX && state_ff.pars[P_SFB2] == SFB_FIX;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed gains wrong");

   property p_prohibit;
      (busy ##1 busy) |-> !fwd_inhibit_out && !rev_inhibit_out;
   endproperty
   a_prohibit: assert property (p_prohibit) else $error("prohibit honoured during run");

   property p_err_clear;
      (!busy && wr_in && addr_in == A_CTRL && wdata_in[CTRL_START] && run_s) |=> !tune_err_out ##1 busy || !busy;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flag not cleared on start");

endmodule

// ---- load_model.sv ----
// Behavioural motor and load facing the autotuning sequencer
`timescale 1ns/10ps
module load_model
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // Motion command and scenario controls
   input  wire logic       run_in,
   input  wire logic       fwd_in,
   input  wire logic       sat_req_in,
   input  wire logic       osc_req_in,
   input  wire logic [2:0] conv_after_in,
   // Estimator view
   output logic            torque_sat_out,
   output logic            oscillation_out,
   output logic            est_done_out
);
   logic [2:0] turns_ff;
   logic       fwd_ff;
   // Faults only show while the motor is driven
   assign torque_sat_out = run_in & sat_req_in;
   assign oscillation_out = run_in & osc_req_in;
   // Converges only after whole reversals; zero means it never settles
   assign est_done_out = run_in && conv_after_in != 3'h0 && turns_ff >= conv_after_in;
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         turns_ff <= 3'h0;
         fwd_ff <= 1'b0;
      end
      else
      begin
         fwd_ff <= fwd_in;
         turns_ff <= !run_in ? 3'h0 : turns_ff + 3'(fwd_ff & !fwd_in);
      end
   end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the autotuning sequencer
`timescale 1ns/10ps
module testbench;
   import tune_pkg::*;
   logic        ref_clk_in, rst_in, wr_in, rd_in, fwd_prohibit_in, rev_prohibit_in, accel_hold_in, no_load_in;
   logic [7:0]  addr_in;
   logic [15:0] wdata_in, rdata_out, accel_out, inertia_est_in;
   logic        drive_error_in, torque_sat_in, oscillation_in, est_done_in, run_cmd_in, motor_run_out;
   logic        deviation_counter_clear_in, limit_near_in, motor_fwd_out, torque_limit_full_out;
   logic        fwd_inhibit_out, rev_inhibit_out, tune_busy_out, tune_err_out;
   logic [5:0]  cause = 6'h00;
   logic [2:0]  conv = 3'h0;
   logic [31:0] seed = 32'h0000_2412;
   int          err_total = 0;
   int          checks = 0;
   assign drive_error_in = cause[0];
   assign run_cmd_in = !cause[3];
   assign deviation_counter_clear_in = cause[4];
   assign limit_near_in = cause[5];
   servo_autotune_sequencer #(.CYCLE_CLKS(32'h0000_0010)) u_dut (.ref_clk_in, .rst_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .run_cmd_in, .deviation_counter_clear_in, .limit_near_in, .fwd_prohibit_in,
      .rev_prohibit_in, .drive_error_in, .torque_sat_in, .oscillation_in, .est_done_in, .accel_hold_in,
      .no_load_in, .inertia_est_in, .motor_run_out, .motor_fwd_out, .accel_out, .torque_limit_full_out,
      .fwd_inhibit_out, .rev_inhibit_out, .tune_busy_out, .tune_err_out);
   load_model u_load (.ref_clk_in, .rst_in, .run_in(motor_run_out), .fwd_in(motor_fwd_out),
      .sat_req_in(cause[1]), .osc_req_in(cause[2]), .conv_after_in(conv), .torque_sat_out(torque_sat_in),
      .oscillation_out(oscillation_in), .est_done_out(est_done_in));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   function logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [15:0] exp_gain(input int s, input logic [3:0] r, input logic [15:0] ine);
      case (s)
         0: return PG1_TBL[r];
         1, 8: return SG_TBL[r];
         2: return SIT1_TBL[r];
         4: return TF1_TBL[r];
         5: return FF_AMT_FIX;
         6: return FF_FLT_FIX;
         7: return PG2_TBL[r];
         9: return SIT2_FIX;
         11: return TF2_TBL[r];
         12: return ine;
         13: return GS_MODE_FIX;
         14: return GS_SET_FIX;
         15: return GS_TIME_FIX;
         16: return GS_LVL_FIX;
         17: return GS_HYS_FIX;
         18: return PG_SW_FIX;
         default: return SFB_FIX;
      endcase
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask
   task automatic gains(input logic [3:0] r, input logic [15:0] ine);
      logic [15:0] d;
      for (int s = 0; s < NPAR; s++)
      begin
         rd(A_PARAM + 8'(s), d);
         chk("gain", d, exp_gain(s, r, ine));
      end
   endtask
   task automatic start(input logic [3:0] r, input logic [3:0] p);
      wr(A_CTRL, {4'h0, p, r, 4'h1});
      #1;
      chk("busy", tune_busy_out, 16'h0001);
      chk("err", tune_err_out, 16'h0000);
      chk("accel", accel_out, ACCEL_RST);
   endtask
   task automatic run_wait(output int n, output int ups, output int revs);
      logic [15:0] last;
      logic        f;
      n = 0;
      ups = 0;
      revs = 0;
      last = accel_out;
      f = motor_fwd_out;
      while (tune_busy_out === 1'b1 && n < 200)
      begin
         @(posedge ref_clk_in);
         #1;
         n++;
         if (tune_busy_out === 1'b1)
         begin
            chk("run", {motor_run_out, torque_limit_full_out, fwd_inhibit_out, rev_inhibit_out}, 16'h000C);
            if (accel_out !== last)
            begin
               chk("accel", accel_out, {last[14:0], 1'b0});
               ups++;
            end
            revs += int'(f & !motor_fwd_out);
         end
         f = motor_fwd_out;
         last = accel_out;
      end
      chk("stop", motor_run_out, 16'h0000);
   endtask
   task automatic give_verdict();
      $display("Checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge ref_clk_in);
      err_total++;
      give_verdict();
   end
   initial
   begin
      int          n, ups, revs, t;
      logic [15:0] d, ine;
      logic [3:0]  r;
      {rst_in, wr_in, rd_in, addr_in, wdata_in, accel_hold_in, no_load_in, inertia_est_in} = '0;
      {fwd_prohibit_in, rev_prohibit_in} = 2'h3;
      rst_in = 1'b1;
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      chk("inhibit", {fwd_inhibit_out, rev_inhibit_out}, 16'h0003);
      gains(4'h0, 16'h0000);
      rd(A_ACCEL, d);
      chk("accel_base", d, ACCEL_RST);
      rd(8'h7F, d);
      chk("unmapped", d, 16'h0000);
      // Corner rigidities F and 0, then a random one with the short pattern
      for (int k = 0; k < 3; k++)
      begin
         ine = rnd();
         r = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : ine[7:4];
         inertia_est_in <= ine;
         start(r, (k == 2) ? (ine[11:8] | 4'h1) : 4'h0);
         wr(A_PARAM, 16'hBEEF);
         run_wait(n, ups, revs);
         t = (k == 2) ? 40 : 80;
         chk("cycles", 16'(revs), 16'h0005);
         chk("doublings", 16'(ups), 16'h0003);
         chk("length", 16'((n + 4 >= t) && (n <= t + 2)), 16'h0001);
         rd(A_STATUS, d);
         chk("status", {9'h000, d[6:0]}, 16'h0054);
         rd(A_CTRL, d);
         chk("ctrl", d, {4'h0, ((k == 2) ? (ine[11:8] | 4'h1) : 4'h0), r, 4'h0});
         gains(r, ine);
      end
      // Early convergence, held acceleration and no load on the shaft
      conv <= 3'h4;
      accel_hold_in <= 1'b1;
      no_load_in <= 1'b1;
      start(4'h5, 4'h0);
      run_wait(n, ups, revs);
      chk("early", {tune_err_out, 3'(ups), 4'(revs)}, 16'h0004);
      rd(A_PARAM + 8'(P_INERTIA), d);
      chk("inertia", d, 16'h0000);
      // Every abort cause once; gains must come back and the flag must set
      for (int c = 0; c < 6; c++)
      begin
         wr(A_PARAM, 16'h0100 + 16'(c));
         start(ine[3:0], 4'h0);
         repeat (10) @(posedge ref_clk_in);
         cause <= 6'h01 << c;
         run_wait(n, ups, revs);
         chk("abort", {tune_err_out, 15'(n < 8)}, 16'h8001);
         cause <= 6'h00;
         repeat (6) @(posedge ref_clk_in);
         rd(A_PARAM, d);
         chk("restore", d, 16'h0100 + 16'(c));
      end
      give_verdict();
   end
endmodule
